/* src/ccsos_pkg.sv */
// constants and types for the cpu clock select and oscillator stabilization block
// What this block does
// - internal clock selected: peripherals get divided internal clock
// - watchdog, monitor, timer tick stay usable internally
// - status bits set shortest first and stay set
// - counter stops at selected time; status limited
package ccsos_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // register byte addresses
  localparam logic [ADDR_W-1:0] MODE_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] MAIN_OSC_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] INT_OSC_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] STAB_STAT_OFS = 8'h0c;
  localparam logic [ADDR_W-1:0] STAB_SEL_OFS = 8'h10;

  // field positions
  localparam int MODE_REQ_INT_BIT = 0;
  localparam int MODE_SRC_XTAL_BIT = 1;
  localparam int MAIN_STOP_BIT = 7;
  localparam int INT_STOP_BIT = 0;

  // stabilization counter shape
  localparam int STAB_N = 5;
  localparam int SEL_W = 3;
  localparam int CNT_W = 17;
  localparam int STAB_UNIT_DEF = 2048;
  localparam logic [5:0] STAB_MULT [STAB_N] = '{6'h01, 6'h04, 6'h08, 6'h10, 6'h20};

  // values after reset
  localparam logic [SEL_W-1:0] SEL_RST = 3'h5;
  localparam logic MODE_REQ_INT_RST = 1'b1;
  localparam logic MAIN_STOP_RST = 1'b0;
  localparam logic INT_STOP_RST = 1'b0;

  // divider counts in internal oscillator edges
  localparam int H1_DIV = 128;
  localparam int PERIPH_DIV_DEF = 2;
  localparam int DIV_W = 8;

  typedef enum logic [1:0] {
    CS_INT = 2'b00,
    CS_TO_XTAL = 2'b01,
    CS_XTAL = 2'b11,
    CS_TO_INT = 2'b10
  } ccsos_state_e;

  // elapsed cycles for status bit idx
  function automatic logic [CNT_W-1:0] stab_thr(input int idx, input int unit);
    stab_thr = CNT_W'(unit * int'(STAB_MULT[idx]));
  endfunction : stab_thr

  // number of status bits enabled by a select code; illegal codes give the longest
  function automatic int sel_count(input logic [SEL_W-1:0] sel);
    if (sel >= 3'h1 && sel <= 3'h5)
      sel_count = int'(sel);
    else
      sel_count = STAB_N;
  endfunction : sel_count

endpackage : ccsos_pkg

/* src/ccsos_stab_if.sv */
// link between the clock select core and the stabilization counter
`timescale 1ns/1ps
`default_nettype none
interface ccsos_stab_if;
  import ccsos_pkg::*;
  logic ce;
  logic restart;
  logic run;
  logic [SEL_W-1:0] sel;
  logic [STAB_N-1:0] status;
  logic done;
  modport ctrl (output ce, output restart, output run, output sel, input status, input done);
  modport cnt (input ce, input restart, input run, input sel, output status, output done);
endinterface : ccsos_stab_if
`default_nettype wire

/* src/ccsos_stab_counter.sv */
// oscillation stabilization counter with sticky elapsed-time status
`timescale 1ns/1ps
`default_nettype none
module ccsos_stab_counter #(
  parameter int STAB_UNIT = ccsos_pkg::STAB_UNIT_DEF
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // control and status
  ccsos_stab_if.cnt stab
);
  import ccsos_pkg::*;

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [STAB_N-1:0] status_r;
  logic [STAB_N-1:0] hit;
  logic [CNT_W-1:0] limit;
  logic done_r;

  assign limit = stab_thr(sel_count(stab.sel) - 1, STAB_UNIT);
  assign cnt_nxt = (stab.run && cnt_r < limit) ? cnt_r + CNT_W'(1) : cnt_r;

  always_comb
  begin
    for (int i = 0; i < STAB_N; i++)
      hit[i] = (cnt_r >= stab_thr(i, STAB_UNIT)) && (i < sel_count(stab.sel));
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      cnt_r <= '0;
      status_r <= '0;
      done_r <= 1'b0;
    end
    else if (stab.ce)
    begin
      if (stab.restart)
      begin
        cnt_r <= '0;
        status_r <= '0;
        done_r <= 1'b0;
      end
      else
      begin
        cnt_r <= cnt_nxt;
        status_r <= status_r | hit;
        done_r <= (cnt_r >= limit);
      end
    end
  end

  assign stab.status = status_r;
  assign stab.done = done_r;

endmodule : ccsos_stab_counter
`default_nettype wire

/* src/ccsos_top.sv */
// cpu clock source select, oscillator stop control and peripheral clock ticks
//
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module ccsos_top #(
  parameter int STAB_UNIT = ccsos_pkg::STAB_UNIT_DEF,
  parameter int PERIPH_DIV = ccsos_pkg::PERIPH_DIV_DEF
) (
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // register port
  input wire logic [ccsos_pkg::ADDR_W-1:0] addr_in,
  input wire logic [ccsos_pkg::DATA_W-1:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [ccsos_pkg::DATA_W-1:0] rd_data_out,
  // cpu standby state
  input wire logic stop_mode_in,
  // internal oscillator output, asynchronous
  input wire logic int_osc_pin_in,
  // oscillator controls
  output logic main_osc_stop_out,
  output logic int_osc_stop_out,
  // clock routing
  output logic cpu_clk_xtal_sel_out,
  output logic periph_src_int_out,
  output logic periph_tick_out,
  output logic int_tick_out,
  output logic h1_tick_out,
  output logic timer_zero_zero_ext_en_out
);
  import ccsos_pkg::*;

  ccsos_stab_if stab ();

  // registers
  logic mode_req_int_r;
  logic main_stop_r;
  logic int_stop_r;
  logic [SEL_W-1:0] stab_sel_r;
  logic [DATA_W-1:0] rd_data_r;

  // clock select state
  ccsos_state_e state_r;
  ccsos_state_e state_nxt;
  logic cpu_xtal_r;
  logic periph_int_r;
  logic timer_zero_zero_en_r;

  // internal oscillator sampling and dividers
  logic rosc_meta_r;
  logic rosc_sync_r;
  logic rosc_prev_r;
  logic rosc_edge;
  logic [DIV_W-1:0] h1_cnt_r;
  logic [DIV_W-1:0] per_cnt_r;
  logic h1_wrap;
  logic per_wrap;
  logic h1_tick_r;
  logic per_tick_r;
  logic int_tick_r;

  // address decode
  logic sel_mode;
  logic sel_main;
  logic sel_int;
  logic sel_stat;
  logic sel_ssel;
  logic wr_mode;
  logic wr_main;
  logic wr_int;
  logic wr_ssel;
  logic main_stop_ok;
  logic int_stop_ok;
  logic [DATA_W-1:0] rd_mux;

  assign sel_mode = (addr_in == MODE_OFS);
  assign sel_main = (addr_in == MAIN_OSC_OFS);
  assign sel_int = (addr_in == INT_OSC_OFS);
  assign sel_stat = (addr_in == STAB_STAT_OFS);
  assign sel_ssel = (addr_in == STAB_SEL_OFS);

  assign wr_mode = wr_in && sel_mode;
  assign wr_main = wr_in && sel_main;
  assign wr_int = wr_in && sel_int;
  assign wr_ssel = wr_in && sel_ssel;

  // an oscillator feeding the cpu can never be stopped; such writes keep the old value
  // judged on the next state so a write landing on a hand-over edge is refused too
  assign main_stop_ok = !wr_data_in[MAIN_STOP_BIT] || (state_nxt == CS_INT);
  assign int_stop_ok = !wr_data_in[INT_STOP_BIT] || (state_nxt == CS_XTAL);

  // read data selection
  always_comb
  begin
    rd_mux = '0;
    if (sel_mode)
    begin
      rd_mux[MODE_REQ_INT_BIT] = mode_req_int_r;
      rd_mux[MODE_SRC_XTAL_BIT] = cpu_xtal_r;
    end
    else if (sel_main)
      rd_mux[MAIN_STOP_BIT] = main_stop_r;
    else if (sel_int)
      rd_mux[INT_STOP_BIT] = int_stop_r;
    else if (sel_stat)
      rd_mux[STAB_N-1:0] = stab.status;
    else if (sel_ssel)
      rd_mux[SEL_W-1:0] = stab_sel_r;
  end

  // register writes and read data
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      mode_req_int_r <= MODE_REQ_INT_RST;
      main_stop_r <= MAIN_STOP_RST;
      int_stop_r <= INT_STOP_RST;
      stab_sel_r <= SEL_RST;
      rd_data_r <= '0;
    end
    else if (ce_in)
    begin
      if (wr_mode)
        mode_req_int_r <= wr_data_in[MODE_REQ_INT_BIT];
      if (wr_main && main_stop_ok)
        main_stop_r <= wr_data_in[MAIN_STOP_BIT];
      if (wr_int && int_stop_ok)
        int_stop_r <= wr_data_in[INT_STOP_BIT];
      if (wr_ssel)
        stab_sel_r <= wr_data_in[SEL_W-1:0];
      rd_data_r <= rd_in ? rd_mux : '0;
    end
  end

  // stabilization counter: restarts in standby or while the crystal is stopped
  assign stab.ce = ce_in;
  assign stab.restart = stop_mode_in || main_stop_r;
  assign stab.run = !stop_mode_in && !main_stop_r;
  assign stab.sel = stab_sel_r;

  ccsos_stab_counter #(
    .STAB_UNIT(STAB_UNIT)
  ) u_stab (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .stab(stab)
  );

  // source switching; one hand-over cycle each way keeps the two sources apart
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      CS_INT:
        if (!mode_req_int_r && !main_stop_r && stab.done)
          state_nxt = CS_TO_XTAL;
      CS_TO_XTAL:
        state_nxt = CS_XTAL;
      CS_XTAL:
        if (mode_req_int_r && !int_stop_r)
          state_nxt = CS_TO_INT;
      CS_TO_INT:
        state_nxt = CS_INT;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      state_r <= CS_INT;
      cpu_xtal_r <= 1'b0;
      periph_int_r <= 1'b1;
      timer_zero_zero_en_r <= 1'b0;
    end
    else if (ce_in)
    begin
      state_r <= state_nxt;
      cpu_xtal_r <= (state_nxt == CS_XTAL) || (state_nxt == CS_TO_INT);
      periph_int_r <= (state_nxt == CS_INT) || (state_nxt == CS_TO_XTAL);
      timer_zero_zero_en_r <= (state_nxt == CS_XTAL) || (state_nxt == CS_TO_INT);
    end
  end

  // internal oscillator pin: two flops, then edge detect on the synced copy
  assign rosc_edge = rosc_sync_r && !rosc_prev_r && !int_stop_r;
  assign h1_wrap = (h1_cnt_r == DIV_W'(H1_DIV - 1));
  assign per_wrap = (per_cnt_r == DIV_W'(PERIPH_DIV - 1));

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      rosc_meta_r <= 1'b0;
      rosc_sync_r <= 1'b0;
      rosc_prev_r <= 1'b0;
    end
    else if (ce_in)
    begin
      rosc_meta_r <= int_osc_pin_in;
      rosc_sync_r <= rosc_meta_r;
      rosc_prev_r <= rosc_sync_r;
    end
  end

  // dividers and ticks
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      h1_cnt_r <= '0;
      per_cnt_r <= '0;
      h1_tick_r <= 1'b0;
      per_tick_r <= 1'b0;
      int_tick_r <= 1'b0;
    end
    else if (ce_in)
    begin
      int_tick_r <= rosc_edge;
      h1_tick_r <= rosc_edge && h1_wrap;
      if (rosc_edge)
      begin
        h1_cnt_r <= h1_wrap ? '0 : h1_cnt_r + DIV_W'(1);
        per_cnt_r <= per_wrap ? '0 : per_cnt_r + DIV_W'(1);
      end
      // on crystal the peripherals run on every system clock
      if (periph_int_r)
        per_tick_r <= rosc_edge && per_wrap;
      else
        per_tick_r <= 1'b1;
    end
  end

  // outputs
  assign rd_data_out = rd_data_r;
  assign main_osc_stop_out = main_stop_r;
  assign int_osc_stop_out = int_stop_r;
  assign cpu_clk_xtal_sel_out = cpu_xtal_r;
  assign periph_src_int_out = periph_int_r;
  assign periph_tick_out = per_tick_r;
  assign int_tick_out = int_tick_r;
  assign h1_tick_out = h1_tick_r;
  assign timer_zero_zero_ext_en_out = timer_zero_zero_en_r;

endmodule : ccsos_top
`default_nettype wire

/* tb/ccsos_assertions.sv */
// port assertions for the clock select block
`timescale 1ns/1ps
`default_nettype none
module ccsos_assertions (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // watched ports
  input wire logic int_osc_pin_in,
  input wire logic main_osc_stop_out,
  input wire logic int_osc_stop_out,
  input wire logic cpu_clk_xtal_sel_out,
  input wire logic periph_src_int_out,
  input wire logic periph_tick_out,
  input wire logic int_tick_out,
  input wire logic h1_tick_out,
  input wire logic timer_zero_zero_ext_en_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  sequence s_on_xtal;
    cpu_clk_xtal_sel_out [*3];
  endsequence
  sequence s_int_stopped;
    int_osc_stop_out [*4];
  endsequence
  AST_SRC: assert property (periph_src_int_out == !cpu_clk_xtal_sel_out)
    else $error("peripheral source differs from cpu source");
  AST_XTAL_TICK: assert property (s_on_xtal |-> periph_tick_out)
    else $error("peripheral tick not steady on crystal");
  AST_TIMER_ZERO_ZERO: assert property (timer_zero_zero_ext_en_out == cpu_clk_xtal_sel_out)
    else $error("timer count edge enabled on internal clock");
  AST_INT_TICK: assert property ($rose(int_osc_pin_in) && !int_osc_stop_out
    |-> ##[2:4] int_tick_out)
    else $error("internal tick missing after pin edge");
  AST_TICK_OFF: assert property (s_int_stopped |-> !int_tick_out)
    else $error("internal tick while oscillator stopped");
  AST_H1_GAP: assert property (h1_tick_out |=> !h1_tick_out [*8])
    else $error("timer tick too frequent");
  AST_MAIN_STOP: assert property (main_osc_stop_out |-> !cpu_clk_xtal_sel_out)
    else $error("crystal stopped while cpu on crystal");
  AST_INT_STOP: assert property (int_osc_stop_out |-> cpu_clk_xtal_sel_out)
    else $error("internal oscillator stopped while cpu on it");
endmodule : ccsos_assertions
bind ccsos_top ccsos_assertions chk_u (.clk_in, .rst_n_in, .int_osc_pin_in,
  .main_osc_stop_out, .int_osc_stop_out, .cpu_clk_xtal_sel_out, .periph_src_int_out,
  .periph_tick_out, .int_tick_out, .h1_tick_out, .timer_zero_zero_ext_en_out);
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench for the clock select block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ccsos_pkg::*;
  localparam int PDIV = 2;
  logic clk_in, rst_n_in, ce_in, wr_in, rd_in, stop_mode_in, int_osc_pin_in;
  logic [7:0] addr_in, wr_data_in, rd_data_out;
  logic main_osc_stop_out, int_osc_stop_out, cpu_clk_xtal_sel_out, periph_src_int_out;
  logic periph_tick_out, int_tick_out, h1_tick_out, timer_zero_zero_ext_en_out, osc_on, ph;
  int error_cnt, n_compared;
  ccsos_top #(.STAB_UNIT(4), .PERIPH_DIV(PDIV)) dut_u (.clk_in, .rst_n_in, .ce_in,
    .addr_in, .wr_data_in, .wr_in, .rd_in, .rd_data_out, .stop_mode_in, .int_osc_pin_in,
    .main_osc_stop_out, .int_osc_stop_out, .cpu_clk_xtal_sel_out, .periph_src_int_out,
    .periph_tick_out, .int_tick_out, .h1_tick_out, .timer_zero_zero_ext_en_out);
  initial
  begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  // internal oscillator runs at a quarter of the clock while enabled
  always @(posedge clk_in)
  begin
    ph <= ~ph;
    if (osc_on && ph)
      int_osc_pin_in <= ~int_osc_pin_in;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wr_data_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input string n, input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    chk(n, e, rd_data_out);
  endtask : rd
  task automatic wait_sel(input logic v);
    for (int i = 0; i < 400 && cpu_clk_xtal_sel_out !== v; i++)
      @(posedge clk_in);
    #1;
    chk("xtal_sel", {7'h00, v}, {7'h00, cpu_clk_xtal_sel_out});
  endtask : wait_sel
  task automatic t_reset;
    rd("mode", 8'h00, 8'h01);
    rd("main", 8'h04, 8'h00);
    rd("int", 8'h08, 8'h00);
    rd("sel", 8'h10, 8'h05);
    wr(8'h44, 8'hff);
    rd("unmapped", 8'h44, 8'h00);
    rd("mode_again", 8'h00, 8'h01);
    @(posedge clk_in);
    #1;
    chk("rd_idle", 8'h00, rd_data_out);
  endtask : t_reset
  task automatic t_ticks;
    int ni;
    int np;
    int k;
    ni = 0;
    np = 0;
    k = 0;
    @(posedge clk_in iff h1_tick_out === 1'b1);
    do
    begin
      @(posedge clk_in);
      ni += int_tick_out;
      np += periph_tick_out;
      k++;
    end while (h1_tick_out !== 1'b1 && k < 2000);
    chk("int_ticks", 8'(H1_DIV), 8'(ni));
    chk("periph_ticks", 8'(H1_DIV / PDIV), 8'(np));
    chk("periph_src", 8'h01, {7'h00, periph_src_int_out});
  endtask : t_ticks
  task automatic t_stab;
    logic [7:0] full;
    for (int s = 0; s < 6; s++)
    begin
      full = (s == 0) ? 8'h1f : 8'((1 << s) - 1);
      wr(8'h10, 8'(s));
      rd("sel", 8'h10, 8'(s));
      @(posedge clk_in);
      stop_mode_in <= 1'b1;
      @(posedge clk_in);
      stop_mode_in <= 1'b0;
      repeat (10) @(posedge clk_in);
      rd("stab_early", 8'h0c, 8'h01);
      repeat (200) @(posedge clk_in);
      rd("stab_full", 8'h0c, full);
    end
  endtask : t_stab
  task automatic t_switch;
    wr(8'h08, 8'h01);
    rd("int_refused", 8'h08, 8'h00);
    wr(8'h04, 8'h80);
    rd("main_stop", 8'h04, 8'h80);
    wr(8'h00, 8'h00);
    repeat (20) @(posedge clk_in);
    chk("held", 8'h00, {7'h00, cpu_clk_xtal_sel_out});
    wr(8'h04, 8'h00);
    wait_sel(1'b1);
    rd("mode_x", 8'h00, 8'h02);
    chk("timer_zero_zero_x", 8'h01, {7'h00, timer_zero_zero_ext_en_out});
    chk("periph_x", 8'h00, {7'h00, periph_src_int_out});
    wr(8'h04, 8'h80);
    rd("main_refused", 8'h04, 8'h00);
    osc_on <= 1'b0;
    wr(8'h08, 8'h01);
    rd("int_stop", 8'h08, 8'h01);
    chk("int_pin", 8'h01, {7'h00, int_osc_stop_out});
    wr(8'h08, 8'h00);
    osc_on <= 1'b1;
    wr(8'h00, 8'h01);
    wait_sel(1'b0);
    rd("mode_i", 8'h00, 8'h01);
    chk("timer_zero_zero_i", 8'h00, {7'h00, timer_zero_zero_ext_en_out});
  endtask : t_switch
  task automatic print_verdict;
    $display("compared %0d mismatched %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict
  initial
  begin
    {rst_n_in, wr_in, rd_in, stop_mode_in, int_osc_pin_in, osc_on, ph} = 7'h00;
    ce_in = 1'b1;
    addr_in = 8'h00;
    wr_data_in = 8'h00;
    error_cnt = 0;
    n_compared = 0;
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    osc_on <= 1'b1;
    t_reset();
    t_ticks();
    t_stab();
    t_switch();
    print_verdict();
  end
  initial
  begin
    #40000;
    error_cnt++;
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
